// ### verilog/external_trigger_handshake.v
// External trigger handshake: trigger input, interlock, completion pulse, APB registers
`include "external_trigger_handshake_defines.vh"

//
// How it works
// RQ1 - Each press of the mode select key flips between external and continuous triggering.
// RQ2 - While waiting for an external trigger, light the indicator and show dashes.
// RQ3 - In external mode each front panel trigger key press takes exactly one reading.
// RQ4 - Completion goes out on one link line, trigger comes in on the other.
// RQ5 - A trigger on the digital I/O pin counts the same as the link input.
// RQ6 - Line triggers are accepted with interlock high or open, ignored while held low.
// RQ7 - The partner pulses the line; the trigger is its falling edge.
// RQ8 - Line triggers are acted on only when the source is external.
// RQ9 - Each accepted trigger takes one reading, stores it, then pulses completion.
// RQ10 - After the completion pulse, return to waiting until the next trigger.
// RQ11 - Scanner closes its first channel untriggered, pulses ready, then waits.
// RQ12 - Scanner closes the next channel on each completion pulse, pulsing ready again.
// RQ13 - Completion output lets other instruments be triggered after settled measurements.
// RQ14 - In external mode the line, the trigger key or a bus command satisfy detection.
// RQ15 - Completion is issued only after the whole measurement action has finished.
// RQ16 - Line and interlock pass two flops before edge detection; pulse length is programmable.
module external_trigger_handshake #(
  parameter DATA_W = 32,
  parameter CNT_W  = 16
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              clk_en,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg               pready,
  output reg  [31:0]       prdata,
  output reg               pslverr,
  // Pins from outside the clock domain
  input  wire              trigger_link_in_n,
  input  wire              dio_trigger_in_n,
  input  wire              interlock_in,
  input  wire              external_mode_select_key,
  input  wire              trigger_key,
  // Measurement engine, same clock domain
  output reg               meas_start,
  input  wire              meas_done,
  input  wire [DATA_W-1:0] meas_data,
  // Reading buffer write port
  output reg               store_wr,
  output reg  [DATA_W-1:0] store_data,
  // Front panel and link outputs
  output reg               trigger_indicator,
  output reg               display_dashes,
  output reg               measurement_complete_output_n
);

  // ****************************************************************
  // Sequencer states, one-hot
  // ****************************************************************
  localparam [3:0] ST_WAIT  = 4'h1;
  localparam [3:0] ST_MEAS  = 4'h2;
  localparam [3:0] ST_STORE = 4'h4;
  localparam [3:0] ST_PULSE = 4'h8;

  // ****************************************************************
  // Constants sized to this module's fields
  // ****************************************************************
  // Sized copies keep every reset and step assignment width-exact
  localparam [1:0]       CTRL_RST = `ETH_CTRL_RESET;
  localparam [CNT_W-1:0] LEN_RST  = `ETH_PULSE_LEN_RESET;
  localparam [CNT_W-1:0] CNT_ONE  = `ETH_CYCLE_ONE;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  wire [`ETH_SYNC_COUNT-1:0] raw_in;
  reg  [`ETH_SYNC_COUNT-1:0] sync1_q;
  reg  [`ETH_SYNC_COUNT-1:0] sync2_q;
  reg  [`ETH_SYNC_COUNT-1:0] prev_q;
  reg  [3:0]                 state_q;
  reg  [3:0]                 state_d;
  reg                        ext_mode_q;
  reg                        run_q;
  reg  [CNT_W-1:0]           pulse_len_q;
  reg  [CNT_W-1:0]           pulse_cnt_q;
  reg  [DATA_W-1:0]          last_rdg_q;
  reg  [31:0]                rdg_count_q;
  reg                        bus_trig_q;
  wire                       line_level;
  wire                       line_prev;
  wire                       line_fall;
  wire                       interlock_ok;
  wire                       mode_key_edge;
  wire                       trig_key_edge;
  wire                       ext_event;
  wire                       accept;
  wire                       apb_setup_done;
  wire                       apb_commit;
  wire                       wr_commit;
  reg  [31:0]                rd_mux;
  reg                        addr_ok;
  wire [31:0]                status_word;
  wire                       st_waiting;
  wire                       st_busy;
  wire                       st_pulsing;
  wire                       line_trig;
  wire                       panel_wait;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  assign raw_in[`ETH_SYNC_LINK]      = trigger_link_in_n;
  assign raw_in[`ETH_SYNC_DIO]       = dio_trigger_in_n;
  assign raw_in[`ETH_SYNC_INTERLOCK] = interlock_in;
  assign raw_in[`ETH_SYNC_MODE_KEY]  = external_mode_select_key;
  assign raw_in[`ETH_SYNC_TRIG_KEY]  = trigger_key;

  // Two flops per pin, then a history flop for edge detection
  // clk_en low holds every stage, so no edge is lost or doubled
  genvar gi;
  generate
    for (gi = 0; gi < `ETH_SYNC_COUNT; gi = gi + 1) begin : g_sync
      // Idle levels preset so reset release gives no false edge
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_q[gi] <= (gi < `ETH_SYNC_MODE_KEY) ? 1'b1 : 1'b0;
          sync2_q[gi] <= (gi < `ETH_SYNC_MODE_KEY) ? 1'b1 : 1'b0;
          prev_q[gi]  <= (gi < `ETH_SYNC_MODE_KEY) ? 1'b1 : 1'b0;
        end else if (clk_en) begin
          sync1_q[gi] <= raw_in[gi];
          sync2_q[gi] <= sync1_q[gi]; // RQ16
          prev_q[gi]  <= sync2_q[gi];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Trigger detection
  // ****************************************************************
  // Link line and I/O pin are one net: low on either pulls it low
  assign line_level    = sync2_q[`ETH_SYNC_LINK] & sync2_q[`ETH_SYNC_DIO]; // RQ5
  assign line_prev     = prev_q[`ETH_SYNC_LINK] & prev_q[`ETH_SYNC_DIO];
  assign line_fall     = line_prev & ~line_level; // RQ7
  assign interlock_ok  = sync2_q[`ETH_SYNC_INTERLOCK]; // RQ6
  assign mode_key_edge = sync2_q[`ETH_SYNC_MODE_KEY] & ~prev_q[`ETH_SYNC_MODE_KEY];
  assign trig_key_edge = sync2_q[`ETH_SYNC_TRIG_KEY] & ~prev_q[`ETH_SYNC_TRIG_KEY];

  // Interlock gates only the line; key and bus command bypass it
  assign line_trig = line_fall & interlock_ok; // RQ6

  // Any of three sources satisfies detection in external mode
  assign ext_event = line_trig | trig_key_edge | bus_trig_q; // RQ14 RQ3
  // Continuous mode triggers itself and ignores the line; external mode waits for an event
  assign accept = run_q & (ext_mode_q ? ext_event : 1'b1); // RQ8

  // ****************************************************************
  // APB handshake, one wait state
  // ****************************************************************
  // Registered pready costs a cycle but keeps all outputs on flops
  assign apb_setup_done = psel & penable & ~pready;
  assign apb_commit     = psel & penable & pready;
  assign wr_commit      = apb_commit & pwrite & addr_ok;

  // Status bits decoded once from the one-hot state
  assign st_waiting = (state_q == ST_WAIT) & ext_mode_q & run_q; // RQ2
  assign st_busy    = state_q != ST_WAIT;
  assign st_pulsing = state_q == ST_PULSE;

  assign status_word = {27'h0000000,
                        st_pulsing,
                        line_level,
                        interlock_ok,
                        st_busy,
                        st_waiting};

  // Read data and address decode
  always @* begin
    rd_mux  = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr)
      `ETH_OFF_CTRL: begin
        rd_mux[`ETH_CTRL_EXT_MODE] = ext_mode_q;
        rd_mux[`ETH_CTRL_RUN]      = run_q;
      end
      `ETH_OFF_PULSE_LEN: begin
        rd_mux[CNT_W-1:0] = pulse_len_q;
      end
      `ETH_OFF_STATUS: begin
        rd_mux = status_word;
      end
      `ETH_OFF_COMMAND: begin
        rd_mux = 32'h00000000;
      end
      `ETH_OFF_LAST_RDG: begin
        rd_mux[DATA_W-1:0] = last_rdg_q;
      end
      `ETH_OFF_RDG_COUNT: begin
        rd_mux = rdg_count_q;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // Answer flops: pready high for exactly one cycle per transfer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= apb_setup_done;
      pslverr <= apb_setup_done & ~addr_ok;
      if (apb_setup_done & ~pwrite) begin
        prdata <= rd_mux;
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // Key press toggles after any bus write in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_mode_q  <= CTRL_RST[`ETH_CTRL_EXT_MODE];
      run_q       <= CTRL_RST[`ETH_CTRL_RUN];
      pulse_len_q <= LEN_RST;
      bus_trig_q  <= 1'b0;
    end else if (clk_en) begin
      if (wr_commit && paddr == `ETH_OFF_CTRL) begin
        ext_mode_q <= pwdata[`ETH_CTRL_EXT_MODE] ^ mode_key_edge; // RQ1
        run_q      <= pwdata[`ETH_CTRL_RUN];
      end else if (mode_key_edge) begin
        ext_mode_q <= ~ext_mode_q; // RQ1
      end
      if (wr_commit && paddr == `ETH_OFF_PULSE_LEN) begin
        pulse_len_q <= pwdata[CNT_W-1:0]; // RQ16
      end
      // Bus trigger is a one-cycle event; lost unless waiting
      bus_trig_q <= wr_commit & (paddr == `ETH_OFF_COMMAND) & pwdata[`ETH_CMD_BUS_TRIG]; // RQ14
    end
  end

  // ****************************************************************
  // Trigger sequencer
  // ****************************************************************
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_WAIT: begin
        if (accept) begin
          state_d = ST_MEAS; // RQ9
        end
      end
      ST_MEAS: begin
        // Completion waits for the whole action to finish
        if (meas_done) begin
          state_d = ST_STORE; // RQ15
        end
      end
      ST_STORE: begin
        state_d = ST_PULSE; // RQ9
      end
      ST_PULSE: begin
        if (pulse_cnt_q <= CNT_ONE) begin
          state_d = ST_WAIT; // RQ10
        end
      end
      default: begin
        state_d = ST_WAIT;
      end
    endcase
  end

  // State, measurement start and buffer store
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= ST_WAIT;
      meas_start  <= 1'b0;
      store_wr    <= 1'b0;
      store_data  <= {DATA_W{1'b0}};
      last_rdg_q  <= {DATA_W{1'b0}};
      rdg_count_q <= 32'h00000000;
    end else if (clk_en) begin
      state_q    <= state_d;
      meas_start <= (state_q == ST_WAIT) & accept; // RQ9
      store_wr   <= 1'b0;
      if (state_q == ST_MEAS && meas_done) begin
        store_wr    <= 1'b1; // RQ9
        store_data  <= meas_data;
        last_rdg_q  <= meas_data;
        rdg_count_q <= rdg_count_q + 32'h00000001;
      end
    end
  end

  // ****************************************************************
  // Completion pulse
  // ****************************************************************
  // Zero length is stretched to one cycle so a pulse always leaves
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_cnt_q                   <= {CNT_W{1'b0}};
      measurement_complete_output_n <= 1'b1;
    end else if (clk_en) begin
      if (state_q == ST_STORE) begin
        pulse_cnt_q                   <= pulse_len_q; // RQ16
        measurement_complete_output_n <= 1'b0; // RQ4 RQ13
      end else if (state_q == ST_PULSE) begin
        if (pulse_cnt_q <= CNT_ONE) begin
          pulse_cnt_q                   <= {CNT_W{1'b0}};
          measurement_complete_output_n <= 1'b1; // RQ10
        end else begin
          pulse_cnt_q <= pulse_cnt_q - CNT_ONE;
        end
      end
    end
  end

  // ****************************************************************
  // Front panel indication
  // ****************************************************************
  // Next-cycle wait view, so the lamp drops on the trigger edge itself
  assign panel_wait = (state_d == ST_WAIT) & ext_mode_q & run_q; // RQ2

  // Indicator and dashes follow the registered wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_indicator <= 1'b0;
      display_dashes    <= 1'b0;
    end else if (clk_en) begin
      trigger_indicator <= panel_wait; // RQ2
      display_dashes    <= panel_wait; // RQ2
    end
  end

endmodule

// ### common/external_trigger_handshake_defines.vh
// Constants for the external trigger handshake block
`ifndef EXTERNAL_TRIGGER_HANDSHAKE_DEFINES_VH
`define EXTERNAL_TRIGGER_HANDSHAKE_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ETH_OFF_CTRL        12'h000
`define ETH_OFF_PULSE_LEN   12'h004
`define ETH_OFF_STATUS      12'h008
`define ETH_OFF_COMMAND     12'h00C
`define ETH_OFF_LAST_RDG    12'h010
`define ETH_OFF_RDG_COUNT   12'h014

// ****************************************************************
// Field positions
// ****************************************************************
`define ETH_CTRL_EXT_MODE   0
`define ETH_CTRL_RUN        1
`define ETH_CMD_BUS_TRIG    0
`define ETH_ST_WAITING      0
`define ETH_ST_BUSY         1
`define ETH_ST_INTERLOCK_OK 2
`define ETH_ST_LINE_LEVEL   3
`define ETH_ST_PULSING      4

// ****************************************************************
// Reset values and counter step
// ****************************************************************
`define ETH_CTRL_RESET      2'h2
`define ETH_PULSE_LEN_RESET 16'h000A
`define ETH_CYCLE_ONE       16'h0001

// ****************************************************************
// Synchroniser input slots
// ****************************************************************
`define ETH_SYNC_LINK       0
`define ETH_SYNC_DIO        1
`define ETH_SYNC_INTERLOCK  2
`define ETH_SYNC_MODE_KEY   3
`define ETH_SYNC_TRIG_KEY   4
`define ETH_SYNC_COUNT      5

`endif

// ### verif/external_trigger_handshake_properties.sv
// Concurrent checks on the trigger handshake block ports
module external_trigger_handshake_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        meas_start,
  input wire logic        meas_done,
  input wire logic        store_wr,
  input wire logic        trigger_indicator,
  input wire logic        display_dashes,
  input wire logic        measurement_complete_output_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] plen_q;
  logic [15:0] low_cnt_q;
  // Shadow of pulse length; bench only rewrites it while no pulse runs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) plen_q <= 16'h000A;
    else if (psel && penable && pready && pwrite && paddr == 12'h004) plen_q <= pwdata[15:0];
  end
  // Low time of the completion pulse, cleared while the line is high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt_q <= 16'h0000;
    else low_cnt_q <= measurement_complete_output_n ? 16'h0000 : low_cnt_q + 16'h0001;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pulse_len_exact: assert property ($rose(measurement_complete_output_n) |->
    low_cnt_q == ((plen_q == 16'h0000) ? 16'h0001 : plen_q)) else $error("completion pulse length wrong");
  a_store_after_done: assert property (store_wr |-> $past(meas_done)) else $error("store without done");
  a_complete_with_store: assert property ($fell(measurement_complete_output_n) |-> $past(store_wr))
    else $error("completion pulse without stored reading");
  a_start_single_cycle: assert property (meas_start |=> !meas_start) else $error("start too long");
  a_store_single_cycle: assert property (store_wr |=> !store_wr[*2]) else $error("double store");
  a_no_start_pulsing: assert property (!measurement_complete_output_n |-> !meas_start)
    else $error("start during completion pulse");
  a_wait_view_match: assert property ((trigger_indicator == display_dashes) && !(meas_start && display_dashes))
    else $error("dashes differ or shown while measuring");
  a_wait_line_idle: assert property (trigger_indicator |-> measurement_complete_output_n)
    else $error("waiting while pulsing");
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready) else $error("wait state count");
  a_apb_err_zero: assert property (pready && pslverr |-> prdata == 32'h0000_0000) else $error("error data");
endmodule

// ### verif/scanner_model.sv
// Behavioural external scanner on the trigger link
module scanner_model #(
  parameter CH     = 3,
  parameter SETTLE = 6
) (
  input  wire logic pclk,
  input  wire logic go,
  input  wire logic complete_n,
  output logic      ready_n,
  output logic      done
);
  timeunit 1ns;
  timeprecision 1ps;
  // One scan pass; the line idles high because the scanner keeps driving it
  initial begin
    ready_n = 1'b1;
    done = 1'b0;
    while (!go) @(posedge pclk);
    for (int i = 0; i < CH; i++) begin
      if (i > 0) @(negedge complete_n);
      repeat (SETTLE) @(posedge pclk);
      ready_n <= 1'b0;
      repeat (3) @(posedge pclk);
      ready_n <= 1'b1;
    end
    @(posedge complete_n);
    done <= 1'b1;
  end
endmodule

// ### verif/external_trigger_handshake_tb.sv
// Self-checking bench for the trigger handshake block
`include "external_trigger_handshake_defines.vh"
module external_trigger_handshake_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, done, link_n;
  logic dio_n = 1, lock = 1, mode_key = 0, trig_key = 0, meas_done = 0, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, meas_data = 0, rd, c;
  wire pready, pslverr, meas_start, store_wr, ind, dash, cmp_n;
  wire [31:0] prdata, store_data;
  int fails = 0, compares = 0, starts = 0, s;
  always #5 pclk = ~pclk;
  external_trigger_handshake dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .trigger_link_in_n(link_n), .dio_trigger_in_n(dio_n), .interlock_in(lock),
    .external_mode_select_key(mode_key), .trigger_key(trig_key), .meas_start(meas_start),
    .meas_done(meas_done), .meas_data(meas_data), .store_wr(store_wr), .store_data(store_data),
    .trigger_indicator(ind), .display_dashes(dash), .measurement_complete_output_n(cmp_n));
  scanner_model scan (.pclk(pclk), .go(go), .complete_n(cmp_n), .ready_n(link_n), .done(done));
  // Measurement engine: answers one cycle after start with fresh data
  always @(posedge pclk) begin
    meas_done <= meas_start;
    if (meas_start === 1'b1) meas_data <= meas_data + 32'h0000_0111;
    if (meas_start === 1'b1) starts++;
    if (store_wr === 1'b1) check(store_data, meas_data);
  end
  task check(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task summarize;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // APB transfer; answer is awaited, never assumed
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // Press a key (0 mode, 1 trigger) or pulse the I/O trigger pin (2)
  task poke(input int k);
    @(posedge pclk);
    if (k == 0) mode_key <= 1; else if (k == 1) trig_key <= 1; else dio_n <= 0;
    repeat (4) @(posedge pclk);
    mode_key <= 0; trig_key <= 0; dio_n <= 1;
    repeat (30) @(posedge pclk);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, `ETH_OFF_CTRL, 0); check(rd, 32'h2);
    apb(0, `ETH_OFF_PULSE_LEN, 0); check(rd, 32'hA);
    apb(0, 12'h018, 0); check({31'h0, er}, 32'h1); check(rd, 32'h0);
    apb(1, `ETH_OFF_CTRL, 0); repeat (20) @(posedge pclk);
    apb(1, `ETH_OFF_PULSE_LEN, 2);
    poke(0); apb(0, `ETH_OFF_CTRL, 0); check(rd, 32'h1);
    apb(1, `ETH_OFF_CTRL, 3); repeat (4) @(posedge pclk);
    check({ind, dash}, 2'h3);
    apb(0, `ETH_OFF_STATUS, 0); check(rd, 32'hD);
    s = starts; poke(1); check(starts - s, 1);
    s = starts; apb(1, `ETH_OFF_COMMAND, 1); repeat (30) @(posedge pclk); check(starts - s, 1);
    lock <= 0; repeat (4) @(posedge pclk);
    apb(0, `ETH_OFF_STATUS, 0); check(rd, 32'h9);
    s = starts; poke(2); check(starts - s, 0);
    lock <= 1; repeat (4) @(posedge pclk);
    poke(2); check(starts - s, 1);
    apb(0, `ETH_OFF_RDG_COUNT, 0); c = rd; s = starts; go <= 1;
    for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge pclk);
    check({31'h0, done}, 32'h1);
    check(starts - s, 3);
    apb(0, `ETH_OFF_RDG_COUNT, 0); check(rd - c, 3);
    apb(0, `ETH_OFF_LAST_RDG, 0); check(rd, meas_data);
    poke(0); apb(0, `ETH_OFF_CTRL, 0); check(rd, 32'h2);
    check(ind, 0);
    summarize;
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fails++;
    summarize;
  end
endmodule
bind external_trigger_handshake external_trigger_handshake_properties props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .meas_start(meas_start), .meas_done(meas_done), .store_wr(store_wr),
  .trigger_indicator(trigger_indicator), .display_dashes(display_dashes),
  .measurement_complete_output_n(measurement_complete_output_n));
